/* File: stp_compare.sv */
`timescale 1ns/1ps
module stp_compare (
    stp_link_if.cmp lnk // Counter and compare values
);
    // One bit wider than the counter so that a zero period means 1024
    wire [stp_pkg::CNT_W:0] cntInc;
    wire [stp_pkg::CNT_W:0] periodP;
    wire [stp_pkg::CNT_W:0] valueA;
    wire [stp_pkg::CNT_W:0] duty;
    wire pIsZero;
    wire aIsZero;

    assign cntInc = {1'b0, lnk.count} + {1'b0, stp_pkg::CNT_ONE};
    assign pIsZero = (lnk.compareP == stp_pkg::COMPARE_P_VALUE_ZERO);
    assign aIsZero = (lnk.compareA == stp_pkg::COMPARE_A_VALUE_RESET);
    assign periodP = {pIsZero, lnk.compareP, {stp_pkg::COMPARE_P_VALUE_SHIFT{1'b0}}};
    assign valueA = {1'b0, lnk.compareA};
    // A match fires on the tick that would reach the value
    assign lnk.aHit = !aIsZero && (cntInc == valueA);
    assign lnk.pHit = !pIsZero && (cntInc == periodP);
    // Swap chooses which value is the duty; a duty at or past period is 100%
    assign duty = lnk.periodDutySwap ? periodP : valueA;
    assign lnk.dutyActive = ({1'b0, lnk.count} < duty);
endmodule

/* File: stp_link_if.sv */
`timescale 1ns/1ps
interface stp_link_if;
    logic [stp_pkg::CNT_W-1:0] count;
    logic [stp_pkg::CNT_W-1:0] compareA;
    logic [stp_pkg::COMPARE_P_VALUE_W-1:0] compareP;
    logic periodDutySwap;
    logic aHit;
    logic pHit;
    logic dutyActive;
    logic [stp_pkg::PIN_N-1:0] pinRise;
    logic [stp_pkg::PIN_N-1:0] pinFall;

    modport core (
        output count, compareA, compareP, periodDutySwap,
        input aHit, pHit, dutyActive, pinRise, pinFall
    );
    modport cmp (
        input count, compareA, compareP, periodDutySwap,
        output aHit, pHit, dutyActive
    );
    modport sync (
        output pinRise, pinFall
    );
endinterface

/* File: stp_pin_src.sv */
`timescale 1ns/1ps
module stp_pin_src (
    input wire logic core_clk, // Timer clock
    output logic trigPin, // Trigger source
    output logic capPin // Capture source
);
    initial begin
        trigPin = 1'b0;
        capPin = 1'b0;
    end
    // Levels move 7 ns after an edge, so the block must synchronise them
    task automatic drive(input logic t, input logic c, input int hold);
        @(posedge core_clk);
        #7;
        trigPin = t;
        capPin = c;
        repeat (hold) @(posedge core_clk);
    endtask
endmodule

/* File: stp_pin_sync.sv */
`timescale 1ns/1ps
module stp_pin_sync (
    input wire logic core_clk, // Timer clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [stp_pkg::PIN_N-1:0] pinRaw, // Asynchronous pins
    stp_link_if.sync lnk // Edge pulses out
);
    // Two flops per pin, then a third only for edge history
    genvar gi;
    generate
        for (gi = 0; gi < stp_pkg::PIN_N; gi++) begin : gPin
            logic meta_q;
            logic sync_q;
            logic prev_q;
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= pinRaw[gi];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end
            // Edges come from the settled stages only
            assign lnk.pinRise[gi] = sync_q & ~prev_q;
            assign lnk.pinFall[gi] = ~sync_q & prev_q;
        end
    endgenerate
endmodule

/* File: stp_pkg.sv */
// How it works
// - A rising run bit triggers the pulse; software or trigger pin sets it.
// - Run going high starts the counter and the pulse leading edge together.
// - Clearing run, by software or compare-A match, ends the pulse.
// - In single pulse a compare-A match raises the compare-A flag.
// - In single pulse the counter returns to zero only on a run rising edge, or by wrapping after 3FF when compare-A is zero.
// - Single pulse ignores compare-P, clear-source and period/duty swap.
// - PWM with swap set clears the counter on compare-A match, setting period.
// - Internal PWM keeps running while pin action is 00 or 01.
// - Clear-source selection has no influence in PWM operation.
// - In capture, pin action picks rising, falling or both; 11 disables capture.
// - In capture the counter starts on run rising and free runs until run falls.
// - Each active capture edge copies the counter into compare-A and flags it.
// - In capture a compare-P match zeroes the counter and raises its flag.
// - In capture a compare-P value of zero lets the counter reach 3FF.
// - Capture drives no output; level, polarity, clear and swap bits do nothing.
// - The counter is ten bits wide and wraps after 3FF.
package stp_pkg;
    localparam int CNT_W = 10;
    localparam int COMPARE_P_VALUE_W = 3;
    localparam int COMPARE_P_VALUE_SHIFT = 7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] COMPARE_A_VALUE_RESET = 10'h000;
    localparam logic [COMPARE_P_VALUE_W-1:0] COMPARE_P_VALUE_ZERO = 3'h0;
    // Operating mode field codes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    // Pin action codes for compare output
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    // Pin action codes for PWM and single pulse
    localparam logic [1:0] ACT_FORCE_OFF = 2'h0;
    localparam logic [1:0] ACT_FORCE_ON = 2'h1;
    localparam logic [1:0] ACT_PWM = 2'h2;
    localparam logic [1:0] ACT_PULSE = 2'h3;
    // Pin action codes for capture edge choice
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_OFF = 2'h3;
    // Pins handled by the synchroniser
    localparam int PIN_TRIG = 0;
    localparam int PIN_CAP = 1;
    localparam int PIN_N = 2;
    // Decoded operating behaviour, one-hot
    typedef enum logic [4:0] {
        OP_CMP = 5'b00001,
        OP_TMR = 5'b00010,
        OP_PWM = 5'b00100,
        OP_PULSE = 5'b01000,
        OP_CAP = 5'b10000
    } stp_op_t;
endpackage

/* File: stp_timer.sv */
`timescale 1ns/1ps
module stp_timer (
    input wire logic core_clk, // 50 MHz clock
    input wire logic arst_n, // Async reset, active low
    input wire logic timerTick, // One-cycle count enable
    input wire logic [1:0] modeSelect, // Operating mode field
    input wire logic [1:0] pinAction, // Pin action field
    input wire logic runSet, // Software sets run bit
    input wire logic runClear, // Software clears run bit
    input wire logic clearSourceSelect, // Compare mode clear source
    input wire logic periodDutySwap, // PWM period/duty swap
    input wire logic outputInitialLevel, // Output level at run start
    input wire logic outputPolarityInvert, // Invert output pin
    input wire logic [stp_pkg::CNT_W-1:0] compareAWrData, // Compare-A write value
    input wire logic compareAWrEn, // Compare-A write strobe
    input wire logic [stp_pkg::COMPARE_P_VALUE_W-1:0] comparePValue, // Compare-P value
    input wire logic externalTriggerPin, // Async trigger pin
    input wire logic captureInputPin, // Async capture pin
    input wire logic flagAClear, // Clears compare-A flag
    input wire logic flagPClear, // Clears compare-P flag
    output logic counterRun, // Run bit state
    output logic [stp_pkg::CNT_W-1:0] counterValue, // Counter state
    output logic [stp_pkg::CNT_W-1:0] compareAValue, // Compare-A register
    output logic flagA, // Compare-A or capture flag
    output logic flagP, // Compare-P flag
    output logic timerIrq, // Either flag set
    output logic outputPin, // Timer output pin level
    output logic outputDriven // Output function in use
);
    stp_link_if lnk();

    logic run_q;
    logic run_d;
    logic [stp_pkg::CNT_W-1:0] count_q;
    logic [stp_pkg::CNT_W-1:0] count_d;
    logic [stp_pkg::CNT_W-1:0] compare_a_value_q;
    logic [stp_pkg::CNT_W-1:0] compare_a_value_d;
    logic flagA_q;
    logic flagA_d;
    logic flagP_q;
    logic flagP_d;
    logic level_q;
    logic level_d;
    logic pin_q;
    logic driven_q;
    logic driven_d;
    stp_pkg::stp_op_t op;

    // Both pins share one synchroniser; bit order follows the package indices
    stp_pin_sync uSync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .pinRaw({captureInputPin, externalTriggerPin}),
        .lnk(lnk)
    );

    // Match and duty decisions are plain compares on the live values
    stp_compare uCmp (
        .lnk(lnk)
    );

    // Values handed to the comparators
    // Compare-P is taken live, so a change acts from the next tick
    assign lnk.count = count_q;
    assign lnk.compareA = compare_a_value_q;
    assign lnk.compareP = comparePValue;
    assign lnk.periodDutySwap = periodDutySwap;

    // Mode decode; pin action 11 under mode 10 is the single pulse
    always_comb begin
        op = stp_pkg::OP_CMP;
        unique case (modeSelect)
            stp_pkg::MODE_CMP: op = stp_pkg::OP_CMP;
            stp_pkg::MODE_CAP: op = stp_pkg::OP_CAP;
            stp_pkg::MODE_PWM: begin
                if (pinAction == stp_pkg::ACT_PULSE) begin
                    op = stp_pkg::OP_PULSE;
                end else begin
                    op = stp_pkg::OP_PWM;
                end
            end
            stp_pkg::MODE_TMR: op = stp_pkg::OP_TMR;
        endcase
    end

    // Named mode and event terms
    wire isCmpLike;
    wire isPwm;
    wire isPulse;
    wire isCap;
    wire trigRise;
    wire capEdge;
    wire runStart;
    wire stepEn;
    wire aEvt;
    wire pEvt;
    wire capEvt;
    wire clrCount;
    wire pulseStop;

    assign isCmpLike = (op == stp_pkg::OP_CMP) || (op == stp_pkg::OP_TMR);
    assign isPwm = (op == stp_pkg::OP_PWM);
    assign isPulse = (op == stp_pkg::OP_PULSE);
    assign isCap = (op == stp_pkg::OP_CAP);
    assign trigRise = lnk.pinRise[stp_pkg::PIN_TRIG];

    // Capture edge choice; code 11 disables capture but not counting
    // A pin change lands two clocks late, so captures lag the pin by that much
    assign capEdge =
        ((pinAction == stp_pkg::EDGE_RISE) && lnk.pinRise[stp_pkg::PIN_CAP]) ||
        ((pinAction == stp_pkg::EDGE_FALL) && lnk.pinFall[stp_pkg::PIN_CAP]) ||
        ((pinAction == stp_pkg::EDGE_BOTH) &&
            (lnk.pinRise[stp_pkg::PIN_CAP] || lnk.pinFall[stp_pkg::PIN_CAP]));
    assign capEvt = isCap && capEdge;

    // A count step happens only on a tick while running and not restarting
    assign runStart = run_d && !run_q;
    assign stepEn = run_q && timerTick && !runStart;
    assign aEvt = stepEn && lnk.aHit;
    assign pEvt = stepEn && lnk.pHit;

    // Clear source per mode; pulse and overflow cases never clear early
    assign clrCount =
        (isCmpLike && (clearSourceSelect ? aEvt : pEvt)) ||
        (isPwm && (periodDutySwap ? aEvt : pEvt)) ||
        (isCap && pEvt);
    assign pulseStop = isPulse && aEvt;

    // Run bit: sets win over clears so a trigger is never lost
    // A trigger in the cycle of a compare-A stop keeps run set with no run start, so the counter is not zeroed and holds
    always_comb begin
        run_d = run_q;
        if (runClear || pulseStop) begin
            run_d = 1'b0;
        end
        if (runSet || (isPulse && trigRise)) begin
            run_d = 1'b1;
        end
    end

    // Counter: zeroed at run start, then steps with ten-bit wrap
    // The match tick replaces the step, so a period is exactly the compare value
    always_comb begin
        count_d = count_q;
        if (runStart) begin
            count_d = stp_pkg::CNT_ZERO;
        end else if (stepEn) begin
            if (clrCount) begin
                count_d = stp_pkg::CNT_ZERO;
            end else if (!pulseStop) begin
                count_d = count_q + stp_pkg::CNT_ONE;
            end
        end
    end

    // Compare-A register: a capture beats a software write in the same cycle
    // Software should not write compare-A while captures are expected
    always_comb begin
        compare_a_value_d = compare_a_value_q;
        if (compareAWrEn) begin
            compare_a_value_d = compareAWrData;
        end
        if (capEvt) begin
            compare_a_value_d = count_q;
        end
    end

    // Flags: compare-P is not raised in compare mode with the A clear source
    // Sets win over clears so that an event in a clearing cycle is not lost
    wire setA;
    wire setP;
    assign setA = (aEvt && !isCap) || capEvt;
    assign setP = pEvt &&
        ((isCmpLike && !clearSourceSelect) || isPwm || isCap);
    always_comb begin
        flagA_d = flagA_q;
        flagP_d = flagP_q;
        if (flagAClear) begin
            flagA_d = 1'b0;
        end
        if (flagPClear) begin
            flagP_d = 1'b0;
        end
        if (setA) begin
            flagA_d = 1'b1;
        end
        if (setP) begin
            flagP_d = 1'b1;
        end
    end

    // Output level before polarity, per operating behaviour
    // Timer and capture modes keep the last level but do not drive the pin
    always_comb begin
        level_d = level_q;
        driven_d = 1'b0;
        unique case (op)
            stp_pkg::OP_CMP: begin
                driven_d = 1'b1;
                if (runStart) begin
                    level_d = outputInitialLevel;
                end else if (aEvt) begin
                    unique case (pinAction)
                        stp_pkg::ACT_NONE: level_d = level_q;
                        stp_pkg::ACT_LOW: level_d = 1'b0;
                        stp_pkg::ACT_HIGH: level_d = 1'b1;
                        stp_pkg::ACT_TOGGLE: level_d = !level_q;
                    endcase
                end
            end
            stp_pkg::OP_TMR: begin
                level_d = level_q;
            end
            stp_pkg::OP_PWM: begin
                // Duty logic runs regardless; the pin action only picks the pin
                driven_d = 1'b1;
                unique case (pinAction)
                    stp_pkg::ACT_FORCE_OFF: level_d = !outputInitialLevel;
                    stp_pkg::ACT_FORCE_ON: level_d = outputInitialLevel;
                    stp_pkg::ACT_PWM: begin
                        level_d = (run_d && lnk.dutyActive) ?
                            outputInitialLevel : !outputInitialLevel;
                    end
                    stp_pkg::ACT_PULSE: level_d = level_q;
                endcase
            end
            stp_pkg::OP_PULSE: begin
                // Pulse follows the run bit alone, so compare-P plays no part
                driven_d = 1'b1;
                level_d = run_d;
            end
            stp_pkg::OP_CAP: begin
                // No output function in capture
                level_d = level_q;
            end
        endcase
    end

    // Run bit register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    // Counter register; a stopped counter keeps its value for software to read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= stp_pkg::CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // Compare-A register, shared by software writes and captures
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            compare_a_value_q <= stp_pkg::COMPARE_A_VALUE_RESET;
        end else begin
            compare_a_value_q <= compare_a_value_d;
        end
    end

    // Sticky flags
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flagA_q <= 1'b0;
            flagP_q <= 1'b0;
        end else begin
            flagA_q <= flagA_d;
            flagP_q <= flagP_d;
        end
    end

    // Level register, kept across modes that do not drive
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

    // Pin registers; polarity applies only where an output is driven, so an
    // undriven pin rests low whatever the polarity bit says
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q <= 1'b0;
            driven_q <= 1'b0;
        end else begin
            pin_q <= driven_d ? (level_d ^ outputPolarityInvert) : 1'b0;
            driven_q <= driven_d;
        end
    end

    // Outputs come straight from registers, except the combined request
    assign counterRun = run_q;
    assign counterValue = count_q;
    assign compareAValue = compare_a_value_q;
    assign flagA = flagA_q;
    assign flagP = flagP_q;
    assign timerIrq = flagA_q || flagP_q;
    assign outputPin = pin_q;
    assign outputDriven = driven_q;
endmodule

/* File: stp_timer_asserts.sv */
`timescale 1ns/1ps
module stp_timer_asserts (
    input wire logic core_clk, // Timer clock
    input wire logic arst_n, // Async reset, active low
    input wire logic timerTick, // Count enable
    input wire logic [1:0] modeSelect, // Mode field
    input wire logic [1:0] pinAction, // Pin action field
    input wire logic runSet, // Run set pulse
    input wire logic periodDutySwap, // Swap bit
    input wire logic outputPolarityInvert, // Invert bit
    input wire logic compareAWrEn, // Compare-A write
    input wire logic [2:0] comparePValue, // Compare-P value
    input wire logic externalTriggerPin, // Trigger pin
    input wire logic captureInputPin, // Capture pin
    input wire logic counterRun, // Run bit
    input wire logic [9:0] counterValue, // Counter
    input wire logic [9:0] compareAValue, // Compare-A register
    input wire logic flagA, // Compare-A flag
    input wire logic flagP, // Compare-P flag
    input wire logic outputPin, // Output level
    input wire logic outputDriven // Output in use
);
    // Decodes shared by several properties
    wire pulseMode = modeSelect == 2'h2 && pinAction == 2'h3;
    wire capMode = modeSelect == 2'h1;
    wire [9:0] nextCount = counterValue + 10'h001;
    wire aHit = counterRun && timerTick && nextCount == compareAValue && compareAValue != 10'h000;
    wire pHit = counterRun && timerTick && nextCount == {comparePValue, 7'h00};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence runStart; $rose(counterRun); endsequence
    sequence stopped2; !counterRun ##1 !counterRun; endsequence
    sequence capRunning; capMode && counterRun && timerTick ##1 counterRun; endsequence
    a_run_zero: assert property (runStart |-> counterValue == 10'h000)
        else $error("counter not zero at run start");
    a_pulse_pin: assert property ($past(pulseMode) && pulseMode && !$past(outputPolarityInvert) |-> outputPin == counterRun)
        else $error("pulse pin differs from run bit");
    a_pulse_stop: assert property (pulseMode && aHit && !runSet |=> !counterRun && flagA && $stable(counterValue))
        else $error("compare-A match did not end pulse");
    a_stop_hold: assert property (stopped2 |-> $stable(counterValue))
        else $error("counter moved while stopped");
    a_cap_count: assert property (capRunning |-> counterValue == ($past(pHit) ? 10'h000 : $past(nextCount)))
        else $error("capture counter step wrong");
    a_cap_flagp: assert property (capMode && pHit && comparePValue != 3'h0 |=> flagP)
        else $error("compare-P flag missing");
    a_cap_edge: assert property (capMode && pinAction == 2'h0 && $rose(captureInputPin) && !flagA |-> ##[2:6] flagA)
        else $error("rising capture not flagged");
    a_cap_off: assert property (capMode && pinAction == 2'h3 ##1 capMode && pinAction == 2'h3 && !compareAWrEn |=> $stable(compareAValue))
        else $error("capture taken while disabled");
    a_cap_noout: assert property (capMode |=> !outputDriven && !outputPin)
        else $error("output driven in capture");
    a_trig_run: assert property (pulseMode && !counterRun && $rose(externalTriggerPin) |-> ##[2:6] counterRun)
        else $error("trigger pin did not start pulse");
    a_pwm_period: assert property (modeSelect == 2'h2 && pinAction != 2'h3 && periodDutySwap && aHit |=> counterValue == 10'h000)
        else $error("compare-A did not end period");
endmodule
bind stp_timer stp_timer_asserts chk (
    .core_clk(core_clk), .arst_n(arst_n), .timerTick(timerTick), .modeSelect(modeSelect),
    .pinAction(pinAction), .runSet(runSet), .periodDutySwap(periodDutySwap),
    .outputPolarityInvert(outputPolarityInvert), .compareAWrEn(compareAWrEn),
    .comparePValue(comparePValue), .externalTriggerPin(externalTriggerPin),
    .captureInputPin(captureInputPin), .counterRun(counterRun), .counterValue(counterValue),
    .compareAValue(compareAValue), .flagA(flagA), .flagP(flagP), .outputPin(outputPin),
    .outputDriven(outputDriven)
);

/* File: test_standard_timer_pulse_capture.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module test_standard_timer_pulse_capture;
    logic core_clk = 1'b0, arst_n = 1'b0, runSet = 1'b0, runClear = 1'b0, hit;
    logic clearSourceSelect = 1'b0, periodDutySwap = 1'b0, compareAWrEn = 1'b0;
    logic flagAClear = 1'b0, flagPClear = 1'b0, externalTriggerPin, captureInputPin;
    logic outputInitialLevel = 1'b0, outputPolarityInvert = 1'b0;
    logic [1:0] modeSelect = 2'h0, pinAction = 2'h0;
    logic [9:0] compareAWrData = 10'h000, counterValue, compareAValue;
    logic [2:0] comparePValue = 3'h0;
    logic counterRun, flagA, flagP, timerIrq, outputPin, outputDriven;
    int n_mismatch = 0, cmp_count = 0, width;
    always #10 core_clk = ~core_clk;
    stp_pin_src src (.core_clk(core_clk), .trigPin(externalTriggerPin), .capPin(captureInputPin));
    // Tick tied high; level and polarity stay low until capture shows they do nothing
    stp_timer dut (.core_clk(core_clk), .arst_n(arst_n), .timerTick(1'b1),
        .modeSelect(modeSelect), .pinAction(pinAction), .runSet(runSet), .runClear(runClear),
        .clearSourceSelect(clearSourceSelect), .periodDutySwap(periodDutySwap),
        .outputInitialLevel(outputInitialLevel), .outputPolarityInvert(outputPolarityInvert),
        .compareAWrData(compareAWrData), .compareAWrEn(compareAWrEn),
        .comparePValue(comparePValue), .externalTriggerPin(externalTriggerPin),
        .captureInputPin(captureInputPin), .flagAClear(flagAClear), .flagPClear(flagPClear),
        .counterRun(counterRun), .counterValue(counterValue), .compareAValue(compareAValue),
        .flagA(flagA), .flagP(flagP), .timerIrq(timerIrq), .outputPin(outputPin),
        .outputDriven(outputDriven));
    // Bench inputs change 2 ns after an edge, except the trigger and capture pins from src, which move 7 ns after
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    // Compare-P at 128 and clear-source/swap at 0 would clear early in other modes
    task automatic t_pulse_sw;
        modeSelect = 2'h2;
        pinAction = 2'h3;
        comparePValue = 3'h1;
        compareAWrData = 10'h0C8;
        pulse(compareAWrEn);
        repeat (2) begin
            pulse(runSet);
            `CHK("runCount", 10'h000, counterValue)
            `CHK("pulseLead", 1'b1, outputPin)
            width = 0;
            while (counterRun && width < 300) begin
                width++;
                tick(1);
            end
            `CHK("pulseWidth", 200, width)
            `CHK("heldCount", 10'h0C7, counterValue)
            `CHK("irq", 1'b1, timerIrq)
            `CHK("flagP", 1'b0, flagP)
            `CHK("pulseTrail", 1'b0, outputPin)
            pulse(flagAClear);
        end
    endtask
    task automatic t_pulse_trig;
        compareAWrData = 10'h3FF;
        pulse(compareAWrEn);
        src.drive(1'b1, 1'b0, 1);
        src.drive(1'b0, 1'b0, 0);
        tick(1);
        width = 0;
        while (!counterRun && width < 10) begin
            width++;
            tick(1);
        end
        `CHK("trigRun", 1'b1, counterRun)
        `CHK("trigCount", 10'h000, counterValue)
        tick(3);
        pulse(runClear);
        `CHK("swStop", 1'b0, outputPin)
        `CHK("swHeld", 10'h004, counterValue)
    endtask
    // Forced pin actions must not stop the period counter
    task automatic t_pwm_swap;
        periodDutySwap = 1'b1;
        compareAWrData = 10'h008;
        pulse(compareAWrEn);
        for (int a = 0; a < 2; a++) begin
            pinAction = a[1:0];
            clearSourceSelect = a[0];
            pulse(flagAClear);
            pulse(runSet);
            width = 0;
            while (counterValue !== 10'h007 && width < 20) begin
                width++;
                tick(1);
            end
            tick(1);
            `CHK("pwmClear", 10'h000, counterValue)
            `CHK("pwmFlagA", 1'b1, flagA)
            `CHK("pwmDrive", 1'b1, outputDriven)
            `CHK("pwmForce", a == 0, outputPin)
            pulse(runClear);
        end
        periodDutySwap = 1'b0;
        clearSourceSelect = 1'b0;
    endtask
    // Counter parked at a known value makes every capture predictable
    task automatic t_capture;
        modeSelect = 2'h1;
        outputInitialLevel = 1'b1;
        outputPolarityInvert = 1'b1;
        pulse(runSet);
        tick(20);
        pulse(runClear);
        `CHK("stopCount", 10'h015, counterValue)
        `CHK("noDrive", 1'b0, outputDriven)
        `CHK("noPin", 1'b0, outputPin)
        compareAWrData = 10'h3FF;
        for (int e = 0; e < 4; e++) begin
            pinAction = e[1:0];
            for (int lv = 1; lv >= 0; lv--) begin
                pulse(compareAWrEn);
                pulse(flagAClear);
                src.drive(1'b0, lv[0], 8);
                tick(1);
                hit = (e == 2) || (e == 1 - lv);
                `CHK("capFlag", hit, flagA)
                `CHK("capValue", hit ? 10'h015 : 10'h3FF, compareAValue)
            end
        end
        pulse(flagPClear);
        pulse(runSet);
        width = 0;
        while (!flagP && width < 200) begin
            width++;
            tick(1);
        end
        `CHK("pPeriod", 128, width)
        `CHK("pClear", 10'h000, counterValue)
        comparePValue = 3'h0;
        pulse(flagPClear);
        tick(1000);
        `CHK("pastPeriod", 10'h3E9, counterValue)
        tick(100);
        `CHK("fullWrap", 1'b0, flagP)
        `CHK("wrapCount", 10'h04D, counterValue)
        pulse(runClear);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #2;
        arst_n = 1'b1;
        tick(1);
        t_pulse_sw();
        t_pulse_trig();
        t_pwm_swap();
        t_capture();
        stop_test();
    end
    // Whole run is near 2000 cycles; allow five times that
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
endmodule
